// >>> logic/lcd_params.svh
// Constants of the character display instruction interface
`ifndef LCD_PARAMS_SVH
`define LCD_PARAMS_SVH

// Clock and oscillator reference
`define CLK_KHZ 100000
`define OSC_REF_KHZ 270
`define OSC_DIV (`CLK_KHZ / `OSC_REF_KHZ)

// Execution times in microseconds
`define EXEC_TIME_US 37
`define HOME_TIME_US 1520
`define ADD_TIME_US 4
`define INIT_TIME_US 10000
`define TICKS(us) (((us) * `OSC_REF_KHZ + 999) / 1000)
`define EXEC_TICKS `TICKS(`EXEC_TIME_US)
`define HOME_TICKS `TICKS(`HOME_TIME_US)
`define ADD_TICKS `TICKS(`ADD_TIME_US)
`define INIT_TICKS `TICKS(`INIT_TIME_US)

// Blink half period in oscillator ticks
`define BLINK_TICKS 102400

// Memory sizes and address map
`define DISP_DEPTH 80
`define PAT_DEPTH 64
`define LINE_LEN 7'd40
`define ONE_LEN 7'd80
`define LINE1_LAST 7'h27
`define LINE2_BASE 7'h40
`define LINE2_LAST 7'h67
`define ONE_LAST 7'h4f
`define SPACE_CODE 8'h20
`define CURSOR_ROW8 4'd7
`define CURSOR_ROW10 4'd10
`define ROWS_8 4'd7
`define ROWS_10 4'd10
`define ROWS_16 4'd15

// Power-on configuration
`define CFG_INIT 8'h82

`endif

// >>> logic/lcd_pkg.sv
// Types of the character display instruction interface
package lcd_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_EXEC = 3'b001,
        ST_ADD = 3'b011,
        ST_CLEAR = 3'b010
    } lcd_state_t;

    typedef struct packed {
        logic bus_width;
        logic two_lines;
        logic font10;
        logic disp_on;
        logic cursor_on;
        logic blink_on;
        logic inc;
        logic shift_en;
    } lcd_cfg_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic reg_select;
        logic [7:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic [15:0] com_select;
        logic [4:0] seg_data;
        logic seg_shift;
        logic seg_latch;
    } panel_t;

endpackage

// >>> logic/lcd_ram.sv
// Two-read-port memory for display and pattern data
`timescale 1ns/1ps
module lcd_ram #(
    parameter int DEPTH = 80,
    parameter int AW = 7
) (
    // Clock
    input wire logic sys_clk,
    input wire logic clk_en,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    // Host read port
    input wire logic [AW-1:0] raddr_a,
    output logic [7:0] rdata_a,
    // Refresh read port
    input wire logic [AW-1:0] raddr_b,
    output logic [7:0] rdata_b
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge sys_clk) begin
        if (clk_en && we && 32'(waddr) < DEPTH) begin
            mem[waddr] <= wdata;
        end
    end

    // Out-of-range addresses read as zero
    always_ff @(posedge sys_clk) begin
        if (clk_en) begin
            rdata_a <= (32'(raddr_a) < DEPTH) ? mem[raddr_a] : 8'h00;
            rdata_b <= (32'(raddr_b) < DEPTH) ? mem[raddr_b] : 8'h00;
        end
    end
endmodule

// >>> logic/char_lcd_instruction_interface.sv
// Character display instruction interface, timing and refresh
//
// Functional notes
// RULE_01: Nibble mode uses upper four lines only
// RULE_02: High nibble first, byte done after second
// RULE_03: Status poll takes two nibble reads
// RULE_04: Wide mode moves a byte per transfer
// RULE_05: Busy during power-on init, about 10 ms
// RULE_06: Init: clear, function, display off, entry
// RULE_07: While busy only status read executes
// RULE_08: Busy high during execution; host polls
// RULE_09: Clear fills spaces, counter to zero
// RULE_10: Home zeroes counter and shift, 1.52 ms
// RULE_11: Entry mode sets direction and shift
// RULE_12: Display control: display, cursor, blink
// RULE_13: Shift moves cursor or display, memory kept
// RULE_14: Function set: width, lines, font
// RULE_15: Bit 6 loads pattern memory address
// RULE_16: Bit 7 loads display memory address
// RULE_17: Status read gives busy and counter
// RULE_18: Cursor sits at counter's display address
// RULE_19: Unused commons stay non-selected
// RULE_20: Burst starts at last address, latch at first
// RULE_21: Refresh reads separate from host accesses
// RULE_22: Host sees only instruction and data registers
// RULE_23: Counter steps after busy clears, 4 us
// RULE_24: Width bit chooses byte or nibble transfers
// RULE_25: Execution times scale with oscillator rate
// RULE_26: Delays counted in oscillator ticks
// RULE_27: Clear busy at least as long as home
`timescale 1ns/1ps
`include "lcd_params.svh"
module char_lcd_instruction_interface import lcd_pkg::*; #(
    parameter int OSC_DIV = `OSC_DIV,
    parameter int BLINK_TICKS = `BLINK_TICKS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Host register port
    input wire host_req_t host_req,
    output logic [7:0] host_rdata,
    output logic busy_flag,
    // Panel drive
    output panel_t panel
);
    lcd_state_t state_reg;
    lcd_cfg_t cfg_reg;
    logic [6:0] addr_counter;
    logic cg_mode_reg;
    logic [6:0] offset_reg;
    logic [11:0] tick_reg;
    logic [6:0] clr_idx_reg;
    logic init_reg;
    logic pend_add_reg;
    logic pend_shift_reg;
    logic settled_reg;
    logic [15:0] div_reg;
    logic osc_tick;
    logic half_wr_reg;
    logic half_rd_reg;
    logic [3:0] hi_nib_reg;
    logic [7:0] rdata_reg;
    logic [16:0] blink_cnt_reg;
    logic blink_phase_reg;
    logic [3:0] row_reg;
    logic [2:0] pos_reg;
    logic [1:0] phase_reg;
    logic scan_run_reg;
    logic [7:0] code_reg;
    logic hit_reg;
    panel_t panel_reg;
    logic nibble;
    logic wr_done;
    logic rd_done;
    logic [7:0] wr_byte;
    logic ready;
    logic accept_wr;
    logic accept_drd;
    logic [7:0] rd_byte;
    logic [7:0] disp_q_a;
    logic [7:0] disp_q_b;
    logic [7:0] pat_q_a;
    logic [7:0] pat_q_b;
    logic disp_we;
    logic pat_we;
    logic [6:0] disp_waddr;
    logic [7:0] disp_wdata;
    logic [6:0] col;
    logic [6:0] scan_addr;
    logic [6:0] scan_idx;
    logic [3:0] char_row;
    logic [3:0] rows_last;
    logic [3:0] cursor_row;
    logic [5:0] pat_raddr;
    logic [4:0] pix;
    logic tall_font;

    // Counter step with line wrap
    function automatic logic [6:0] ac_step(input logic [6:0] a, input logic up,
                                           input logic cg, input logic two);
        logic [6:0] r;
        r = up ? a + 7'd1 : a - 7'd1;
        if (cg) begin
            r = {1'b0, r[5:0]};
        end else if (two) begin
            if (up && a == `LINE1_LAST) begin
                r = `LINE2_BASE;
            end else if (up && a == `LINE2_LAST) begin
                r = 7'h00;
            end else if (!up && a == 7'h00) begin
                r = `LINE2_LAST;
            end else if (!up && a == `LINE2_BASE) begin
                r = `LINE1_LAST;
            end
        end else begin
            if (up && a == `ONE_LAST) begin
                r = 7'h00;
            end else if (!up && a == 7'h00) begin
                r = `ONE_LAST;
            end
        end
        return r;
    endfunction

    // Display shift offset step within one line
    function automatic logic [6:0] offset_step(input logic [6:0] o, input logic up,
                                               input logic two);
        logic [6:0] len;
        len = two ? `LINE_LEN : `ONE_LEN;
        if (up) begin
            return (o == len - 7'd1) ? 7'h00 : o + 7'd1;
        end
        return (o == 7'h00) ? len - 7'd1 : o - 7'd1;
    endfunction

    // Second line stored after the first
    function automatic logic [6:0] disp_index(input logic [6:0] a, input logic two);
        return (two && a[6]) ? a - `LINE2_BASE + `LINE_LEN : a;
    endfunction

    // Oscillator tick divider
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            div_reg <= 16'h0000;
        end else if (clk_en) begin
            div_reg <= (div_reg == 16'(OSC_DIV - 1)) ? 16'h0000 : div_reg + 16'h0001;
        end
    end
    assign osc_tick = clk_en && div_reg == 16'(OSC_DIV - 1); // RULE_25

    // Transfer assembly
    assign nibble = !cfg_reg.bus_width; // RULE_24
    assign wr_done = host_req.wr && (!nibble || half_wr_reg); // RULE_02
    assign rd_done = host_req.rd && (!nibble || half_rd_reg); // RULE_03
    assign wr_byte = nibble ? {hi_nib_reg, host_req.wdata[7:4]} : host_req.wdata; // RULE_01 RULE_04
    assign ready = state_reg == ST_IDLE && settled_reg;
    assign accept_wr = clk_en && wr_done && ready; // RULE_07
    assign accept_drd = clk_en && rd_done && host_req.reg_select && ready; // RULE_07
    assign busy_flag = state_reg == ST_EXEC || state_reg == ST_CLEAR; // RULE_08 RULE_05

    // Status or data byte
    always_comb begin
        if (!host_req.reg_select) begin
            rd_byte = {busy_flag, addr_counter}; // RULE_17 RULE_22
        end else if (ready) begin
            rd_byte = cg_mode_reg ? pat_q_a : disp_q_a;
        end else begin
            rd_byte = 8'h00;
        end
    end

    // Host port: nibble halves and read data
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            half_wr_reg <= 1'b0;
            half_rd_reg <= 1'b0;
            hi_nib_reg <= 4'h0;
            rdata_reg <= 8'h00;
        end else if (clk_en) begin
            if (host_req.wr) begin
                hi_nib_reg <= host_req.wdata[7:4];
                half_wr_reg <= nibble && !half_wr_reg; // RULE_02
            end
            if (host_req.rd) begin
                half_rd_reg <= nibble && !half_rd_reg;
                if (!nibble) begin
                    rdata_reg <= rd_byte; // RULE_04
                end else if (!half_rd_reg) begin
                    rdata_reg <= {rd_byte[7:4], 4'h0}; // RULE_03
                end else begin
                    rdata_reg <= {rd_byte[3:0], 4'h0}; // RULE_03
                end
            end else begin
                rdata_reg <= 8'h00;
            end
        end
    end
    assign host_rdata = rdata_reg;

    // Instruction execution and timing
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_CLEAR;
            init_reg <= 1'b1;
            cfg_reg <= `CFG_INIT;
            addr_counter <= 7'h00;
            cg_mode_reg <= 1'b0;
            offset_reg <= 7'h00;
            tick_reg <= 12'h000;
            clr_idx_reg <= 7'h00;
            pend_add_reg <= 1'b0;
            pend_shift_reg <= 1'b0;
        end else if (clk_en) begin
            case (state_reg)
                ST_IDLE: begin
                    if (accept_wr || accept_drd) begin
                        tick_reg <= 12'(`EXEC_TICKS); // RULE_26
                        state_reg <= ST_EXEC;
                        pend_add_reg <= host_req.reg_select; // RULE_23
                        pend_shift_reg <= accept_wr && host_req.reg_select && cfg_reg.shift_en && !cg_mode_reg;
                    end
                    if (accept_wr && !host_req.reg_select) begin
                        casez (wr_byte)
                            8'b1???????: begin
                                addr_counter <= wr_byte[6:0]; // RULE_16
                                cg_mode_reg <= 1'b0;
                            end
                            8'b01??????: begin
                                addr_counter <= {1'b0, wr_byte[5:0]}; // RULE_15
                                cg_mode_reg <= 1'b1;
                            end
                            8'b001?????: begin
                                cfg_reg.bus_width <= wr_byte[4]; // RULE_14
                                cfg_reg.two_lines <= wr_byte[3];
                                cfg_reg.font10 <= wr_byte[2];
                                offset_reg <= 7'h00;
                            end
                            8'b0001????: begin
                                if (wr_byte[3]) begin
                                    offset_reg <= offset_step(offset_reg, !wr_byte[2],
                                                              cfg_reg.two_lines); // RULE_13
                                end else begin
                                    addr_counter <= ac_step(addr_counter, wr_byte[2],
                                                            cg_mode_reg, cfg_reg.two_lines); // RULE_13
                                end
                            end
                            8'b00001???: begin
                                cfg_reg.disp_on <= wr_byte[2]; // RULE_12
                                cfg_reg.cursor_on <= wr_byte[1];
                                cfg_reg.blink_on <= wr_byte[0];
                            end
                            8'b000001??: begin
                                cfg_reg.inc <= wr_byte[1]; // RULE_11
                                cfg_reg.shift_en <= wr_byte[0];
                            end
                            8'b0000001?: begin
                                addr_counter <= 7'h00; // RULE_10
                                cg_mode_reg <= 1'b0;
                                offset_reg <= 7'h00;
                                tick_reg <= 12'(`HOME_TICKS); // RULE_10
                            end
                            8'b00000001: begin
                                clr_idx_reg <= 7'h00; // RULE_09
                                state_reg <= ST_CLEAR;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                ST_CLEAR: begin
                    clr_idx_reg <= clr_idx_reg + 7'd1;
                    if (clr_idx_reg == 7'(`DISP_DEPTH - 1)) begin
                        addr_counter <= 7'h00; // RULE_09
                        cg_mode_reg <= 1'b0;
                        offset_reg <= 7'h00;
                        cfg_reg.inc <= 1'b1;
                        state_reg <= ST_EXEC;
                        init_reg <= 1'b0;
                        if (init_reg) begin
                            cfg_reg <= `CFG_INIT; // RULE_06
                            tick_reg <= 12'(`INIT_TICKS); // RULE_05
                        end else begin
                            tick_reg <= 12'(`HOME_TICKS); // RULE_27
                        end
                    end
                end
                ST_EXEC: begin
                    if (osc_tick) begin
                        if (tick_reg <= 12'h001) begin
                            tick_reg <= 12'(`ADD_TICKS);
                            state_reg <= pend_add_reg ? ST_ADD : ST_IDLE;
                        end else begin
                            tick_reg <= tick_reg - 12'h001; // RULE_26
                        end
                    end
                end
                ST_ADD: begin
                    if (osc_tick) begin
                        if (tick_reg <= 12'h001) begin
                            addr_counter <= ac_step(addr_counter, cfg_reg.inc,
                                                    cg_mode_reg, cfg_reg.two_lines); // RULE_23
                            if (pend_shift_reg) begin
                                offset_reg <= offset_step(offset_reg, cfg_reg.inc, cfg_reg.two_lines);
                            end
                            pend_add_reg <= 1'b0;
                            pend_shift_reg <= 1'b0;
                            state_reg <= ST_IDLE;
                        end else begin
                            tick_reg <= tick_reg - 12'h001; // RULE_23
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Read port settles one cycle after idle
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            settled_reg <= 1'b0;
        end else if (clk_en) begin
            settled_reg <= state_reg == ST_IDLE;
        end
    end

    // Host and clear writes
    assign disp_we = state_reg == ST_CLEAR || (accept_wr && host_req.reg_select && !cg_mode_reg);
    assign pat_we = accept_wr && host_req.reg_select && cg_mode_reg;
    assign disp_waddr = (state_reg == ST_CLEAR) ? clr_idx_reg
                                                : disp_index(addr_counter, cfg_reg.two_lines);
    assign disp_wdata = (state_reg == ST_CLEAR) ? `SPACE_CODE : wr_byte; // RULE_09

    // Blink phase
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            blink_cnt_reg <= 17'h00000;
            blink_phase_reg <= 1'b0;
        end else if (osc_tick) begin
            if (blink_cnt_reg == 17'(BLINK_TICKS - 1)) begin
                blink_cnt_reg <= 17'h00000;
                blink_phase_reg <= !blink_phase_reg;
            end else begin
                blink_cnt_reg <= blink_cnt_reg + 17'h00001;
            end
        end
    end

    // Refresh addressing
    assign tall_font = cfg_reg.font10 && !cfg_reg.two_lines;
    assign rows_last = cfg_reg.two_lines ? `ROWS_16 : (tall_font ? `ROWS_10 : `ROWS_8);
    assign cursor_row = tall_font ? `CURSOR_ROW10 : `CURSOR_ROW8;
    assign char_row = cfg_reg.two_lines ? {1'b0, row_reg[2:0]} : row_reg;
    always_comb begin
        col = 7'({4'h0, pos_reg} + offset_reg);
        if (col >= (cfg_reg.two_lines ? `LINE_LEN : `ONE_LEN)) begin
            col = col - (cfg_reg.two_lines ? `LINE_LEN : `ONE_LEN);
        end
        scan_addr = (cfg_reg.two_lines && row_reg[3]) ? `LINE2_BASE + col : col;
        scan_idx = disp_index(scan_addr, cfg_reg.two_lines); // RULE_21
    end
    assign pat_raddr = tall_font ? {disp_q_b[2:1], char_row} : {disp_q_b[2:0], char_row[2:0]};

    // Pixel row with cursor and blink
    always_comb begin
        pix = (code_reg[7:4] == 4'h0) ? pat_q_b[4:0] : 5'h00;
        if (hit_reg && cfg_reg.blink_on && blink_phase_reg) begin
            pix = 5'h00;
        end
        if (hit_reg && cfg_reg.cursor_on && char_row == cursor_row) begin
            pix = 5'h1f; // RULE_18
        end
        if (!cfg_reg.disp_on) begin
            pix = 5'h00;
        end
    end

    // Row scanner: last position first, latch on the first
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            row_reg <= 4'h0;
            pos_reg <= 3'h7;
            phase_reg <= 2'h0;
            scan_run_reg <= 1'b0;
            code_reg <= 8'h00;
            hit_reg <= 1'b0;
            panel_reg <= '0;
        end else if (clk_en) begin
            panel_reg.seg_shift <= 1'b0;
            panel_reg.seg_latch <= 1'b0;
            if (!scan_run_reg) begin
                if (osc_tick) begin
                    scan_run_reg <= 1'b1;
                    pos_reg <= 3'h7; // RULE_20
                    phase_reg <= 2'h0;
                end
            end else if (phase_reg == 2'h0) begin
                phase_reg <= 2'h1;
            end else if (phase_reg == 2'h1) begin
                code_reg <= disp_q_b;
                hit_reg <= !cg_mode_reg && scan_addr == addr_counter; // RULE_18
                phase_reg <= 2'h2;
            end else begin
                panel_reg.seg_data <= pix;
                panel_reg.seg_shift <= 1'b1;
                phase_reg <= 2'h0;
                if (pos_reg == 3'h0) begin
                    panel_reg.seg_latch <= 1'b1; // RULE_20
                    panel_reg.com_select <= 16'h0001 << row_reg; // RULE_19
                    row_reg <= (row_reg >= rows_last) ? 4'h0 : row_reg + 4'h1; // RULE_19
                    scan_run_reg <= 1'b0;
                end else begin
                    pos_reg <= pos_reg - 3'h1;
                end
            end
        end
    end
    assign panel = panel_reg;

    lcd_ram #(
        .DEPTH(`DISP_DEPTH),
        .AW(7)
    ) u_display_mem (
        .sys_clk(sys_clk),
        .clk_en(clk_en),
        .we(disp_we),
        .waddr(disp_waddr),
        .wdata(disp_wdata),
        .raddr_a(disp_index(addr_counter, cfg_reg.two_lines)),
        .rdata_a(disp_q_a),
        .raddr_b(scan_idx),
        .rdata_b(disp_q_b)
    );

    lcd_ram #(
        .DEPTH(`PAT_DEPTH),
        .AW(6)
    ) u_pattern_mem (
        .sys_clk(sys_clk),
        .clk_en(clk_en),
        .we(pat_we),
        .waddr(addr_counter[5:0]),
        .wdata(wr_byte),
        .raddr_a(addr_counter[5:0]),
        .rdata_a(pat_q_a),
        .raddr_b(pat_raddr),
        .rdata_b(pat_q_b)
    );
endmodule

// >>> verification/lcd_iface_props.sv
// Checker of the display interface ports
`timescale 1ns/1ps
`include "lcd_params.svh"
module lcd_iface_props import lcd_pkg::*; #(
    parameter int OSC_DIV = 4
) (
    // Watched ports
    input wire logic sys_clk,
    input wire logic resetn,
    input wire host_req_t host_req,
    input wire logic [7:0] host_rdata,
    input wire logic busy_flag,
    input wire panel_t panel
);
    localparam int MIN_BUSY = (`EXEC_TICKS - 1) * OSC_DIV;
    localparam int MAX_BUSY = (`INIT_TICKS + 1) * OSC_DIV + 100;
    int busy_len;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) busy_len <= 0;
        else busy_len <= busy_flag ? busy_len + 1 : 0;
    end
    property p_rdata_idle; !$past(host_req.rd) |-> host_rdata == 8'h00; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("stray read data");
    property p_busy_stat; host_req.rd && !host_req.reg_select && busy_flag ##1 busy_flag |-> host_rdata[7]; endproperty
    a_busy_stat: assert property (p_busy_stat) else $error("status hides busy");
    property p_refused; host_req.rd && host_req.reg_select && busy_flag ##1 busy_flag |-> host_rdata == 8'h00; endproperty
    a_refused: assert property (p_refused) else $error("data read while busy");
    property p_busy_cause; $rose(busy_flag) |-> $past(host_req.wr || host_req.rd); endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy without write");
    property p_busy_min; $fell(busy_flag) |-> busy_len >= MIN_BUSY; endproperty
    a_busy_min: assert property (p_busy_min) else $error("busy too short");
    property p_busy_max; busy_len <= MAX_BUSY; endproperty
    a_busy_max: assert property (p_busy_max) else $error("busy too long");
    property p_shift; panel.seg_shift |=> !panel.seg_shift [*2]; endproperty
    a_shift: assert property (p_shift) else $error("shift spacing");
    property p_latch; panel.seg_latch |-> panel.seg_shift && $past(panel.seg_shift, 3); endproperty
    a_latch: assert property (p_latch) else $error("latch outside burst");
    property p_com; $onehot0(panel.com_select); endproperty
    a_com: assert property (p_com) else $error("several commons");
endmodule
bind char_lcd_instruction_interface lcd_iface_props #(.OSC_DIV(OSC_DIV)) lcd_iface_props_inst (
    .sys_clk(sys_clk), .resetn(resetn), .host_req(host_req),
    .host_rdata(host_rdata), .busy_flag(busy_flag), .panel(panel));

// >>> verification/mpu_host_model.sv
// Processor side model driving the register port
`timescale 1ns/1ps
module mpu_host_model import lcd_pkg::*; (
    // Register port
    input wire logic sys_clk,
    output host_req_t host_req,
    input wire logic [7:0] host_rdata,
    input wire logic busy_flag
);
    logic nibble = 1'b0;
    initial host_req = '0;
    task automatic put(input logic rs, input logic w, input logic [7:0] d);
        @(posedge sys_clk);
        host_req <= '{wr: w, rd: !w, reg_select: rs, wdata: d};
        @(posedge sys_clk);
        host_req <= '{wr: 1'b0, rd: 1'b0, reg_select: !rs, wdata: ~d};
    endtask
    task automatic wr(input logic rs, input logic [7:0] d);
        if (nibble) begin
            put(rs, 1'b1, {d[7:4], ~d[3:0]});
            put(rs, 1'b1, {d[3:0], d[7:4]});
        end else begin
            put(rs, 1'b1, d);
        end
    endtask
    task automatic rd(input logic rs, output logic [7:0] q);
        put(rs, 1'b0, 8'h00);
        #1 q = host_rdata;
        if (nibble) begin
            put(rs, 1'b0, 8'h00);
            #1 q = {q[7:4], host_rdata[7:4]};
        end
    endtask
    task automatic idle();
        @(posedge sys_clk);
        for (int i = 0; i < 20000 && busy_flag !== 1'b0; i++) @(posedge sys_clk);
        repeat (16) @(posedge sys_clk);
    endtask
endmodule

// >>> verification/char_lcd_instruction_interface_bench.sv
// Self-checking bench of the display interface
`timescale 1ns/1ps
`include "lcd_params.svh"
module char_lcd_instruction_interface_bench import lcd_pkg::*; ;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    host_req_t host_req;
    logic [7:0] host_rdata, q, a, d;
    logic busy_flag;
    panel_t panel;
    logic [15:0] coms = 16'h0000;
    logic [31:0] seed = 32'd6617;
    int err_count = 0, tests_run = 0, cycles = 0, n;
    always #5 sys_clk = ~sys_clk;
    char_lcd_instruction_interface #(.OSC_DIV(4), .BLINK_TICKS(4)) char_lcd_instruction_interface_inst (
        .sys_clk(sys_clk), .resetn(resetn), .clk_en(1'b1), .host_req(host_req),
        .host_rdata(host_rdata), .busy_flag(busy_flag), .panel(panel));
    mpu_host_model mpu_host_model_inst (
        .sys_clk(sys_clk), .host_req(host_req), .host_rdata(host_rdata), .busy_flag(busy_flag));
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] step(input logic [7:0] v, input logic up);
        return up ? v + 8'h01 : v - 8'h01;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task automatic end_of_test();
        $display("%0d mismatches in %0d checks", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic r(input logic rs);
        mpu_host_model_inst.rd(rs, q);
    endtask
    task automatic idle();
        mpu_host_model_inst.idle();
    endtask
    task automatic op(input logic rs, input logic [7:0] c);
        mpu_host_model_inst.wr(rs, c);
        idle();
        r(1'b0);
    endtask
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (busy_flag === 1'b0) coms <= coms | panel.com_select;
        if (cycles == 60000) begin
            err_count++;
            end_of_test();
        end
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        r(1'b0);
        check({7'h00, q[7]}, 8'h01);
        idle();
        r(1'b0);
        check(q, 8'h00);
        for (int i = 0; i < 4; i++) begin
            seed = xorshift(seed);
            a = 8'h01 + seed[5:0] % 8'd38;
            d = seed[15:8];
            op(1'b0, 8'h80 | a);
            check(q, a);
            op(1'b1, d);
            check(q, step(a, 1'b1));
            op(1'b0, 8'h80 | a);
            r(1'b1);
            check(q, d);
            idle();
        end
        mpu_host_model_inst.wr(1'b0, 8'h80);
        r(1'b1);
        check(q, 8'h00);
        op(1'b0, 8'h80 | a);
        check(q, 8'h00);
        op(1'b0, 8'h04);
        op(1'b0, 8'h80 | a);
        op(1'b1, d);
        check(q, step(a, 1'b0));
        op(1'b0, 8'h14);
        check(q, a);
        op(1'b0, 8'h1c);
        check(q, a);
        op(1'b0, 8'h0f);
        check(q, a);
        r(1'b1);
        check(q, d);
        idle();
        for (int k = 0; k < 2; k++) begin
            mpu_host_model_inst.wr(1'b0, k ? 8'h01 : 8'h03);
            @(posedge sys_clk);
            for (n = 1; n < 9000 && busy_flag !== 1'b0; n++) @(posedge sys_clk);
            check({7'h00, n >= (`HOME_TICKS - 2) * 4}, 8'h01);
            op(1'b0, 8'h80 | a);
            r(1'b1);
            check(q, k ? 8'h20 : d);
            idle();
        end
        op(1'b0, 8'h6a);
        check(q, 8'h2a);
        op(1'b1, d);
        op(1'b0, 8'h6a);
        r(1'b1);
        check(q, d);
        idle();
        mpu_host_model_inst.wr(1'b0, 8'h20);
        idle();
        mpu_host_model_inst.nibble = 1'b1;
        op(1'b0, 8'hb5);
        check(q, 8'h35);
        op(1'b1, d);
        check(q, 8'h36);
        mpu_host_model_inst.wr(1'b0, 8'h30);
        mpu_host_model_inst.nibble = 1'b0;
        idle();
        op(1'b0, 8'h81);
        check(q, 8'h01);
        check(coms[15:8], 8'h00);
        end_of_test();
    end
endmodule
